// [common/ssdp_defines.vh]
`ifndef SSDP_DEFINES_VH
`define SSDP_DEFINES_VH

// --------------------------------------------------------------------------
// Register indices; the APB byte address is four times the index.
// --------------------------------------------------------------------------
`define SSDP_IDX_DATA      8'h31
`define SSDP_IDX_CTRL      8'h32
`define SSDP_IDX_STAT      8'h33

// --------------------------------------------------------------------------
// Reset values.
// --------------------------------------------------------------------------
`define SSDP_CTRL_RST      8'h00
`define SSDP_STAT_RST      8'h00
`define SSDP_DATA_RST      8'h00

// --------------------------------------------------------------------------
// Control register fields.
// --------------------------------------------------------------------------
`define SSDP_C_IRQ_EN      7
`define SSDP_C_PEN         6
`define SSDP_C_DIV2        5
`define SSDP_C_MASTER_SELECT        4
`define SSDP_C_CPOL        3
`define SSDP_C_CPHA        2
`define SSDP_C_SPR1        1
`define SSDP_C_SPR0        0

// --------------------------------------------------------------------------
// Status register fields.
// --------------------------------------------------------------------------
`define SSDP_S_DONE        7
`define SSDP_S_WRITE_COLLISION_FLAG        6
`define SSDP_S_OVR         5
`define SSDP_S_MODE_FAULT_FLAG        4
`define SSDP_S_SOD         2
`define SSDP_S_SSM         1
`define SSDP_S_SSI         0

// --------------------------------------------------------------------------
// Serial timing: sixteen clock edges per byte, fast and slow master half periods.
// --------------------------------------------------------------------------
`define SSDP_LAST_EDGE     4'hf
`define SSDP_HALF_FAST     8'h02
`define SSDP_HALF_SLOW     8'h04

`endif

// [hdl/ssdp_core.v]
// Design decision made here: the APB register port.
`timescale 1ns/100ps
`include "ssdp_defines.vh"

// Functional notes
// [RULE_01] Set done flag at byte end; interrupt if enabled.
// [RULE_02] Done clears: status read, then data access.
// [RULE_03] Data writes ignored while done pending unread.
// [RULE_04] Data write during transfer sets write collision.
// [RULE_05] Byte arriving with done set flags overrun.
// [RULE_06] Status read clears overrun flag.
// [RULE_07] Master seeing select low sets mode fault.
// [RULE_08] Fault clears: status access, then control write.
// [RULE_09] Output-disable or peripheral off stops data output.
// [RULE_10] Software select ignores pin, frees it.
// [RULE_11] Internal level 0 selects, 1 deselects.
// [RULE_12] Master data write starts one byte exchange.
// [RULE_13] Received byte copied to buffer; reads return buffer.
// [RULE_14] Data write loads shift register directly.
// [RULE_15] Software writes zero to status bit 3.
// [RULE_16] Data, control, status at consecutive indices.
// [RULE_17] Status resets to zero; event flags read-only.
// [RULE_18] One interrupt from done, fault or overrun.
// [RULE_19] Mode fault clears enable and master bits.
// [RULE_20] Second reception before clear sets overrun.
// [RULE_21] Collision clears by same sequence as done.
// [RULE_22] Discarded data write leaves shifting undisturbed.
module ssdp_core #(
  parameter ADDR_W = 12
) (
  input  wire              core_clk,
  input  wire              rst_n,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              sck_i,
  output reg               sck_o,
  output reg               sck_oe,
  input  wire              mosi_i,
  output reg               mosi_o,
  output reg               mosi_oe,
  input  wire              miso_i,
  output reg               miso_o,
  output reg               miso_oe,
  input  wire              ss_n_i,
  output reg               ss_pin_free,
  output reg               irq
);

  // --------------------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------------------
  wire [3:0] pins_s;
  wire       sck_s;
  wire       mosi_s;
  wire       miso_s;
  wire       ss_n_s;

  ssdp_sync #(
    .W       (4),
    .RST_VAL (4'h8)
  ) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .pin_in   ({ss_n_i, miso_i, mosi_i, sck_i}),
    .pin_sync (pins_s)
  );

  assign sck_s  = pins_s[0];
  assign mosi_s = pins_s[1];
  assign miso_s = pins_s[2];
  assign ss_n_s = pins_s[3];

  // --------------------------------------------------------------------------
  // Registers and engine state.
  // --------------------------------------------------------------------------
  reg  [7:0] ctrl_q;
  reg        done_q;
  reg        write_collision_flag_q;
  reg        ovr_q;
  reg        mode_fault_flag_q;
  reg        sod_q;
  reg        ssm_q;
  reg        ssi_q;
  reg        stat_seen_q;
  reg        mode_fault_flag_arm_q;
  reg  [7:0] rx_buf_q;
  reg  [7:0] shift_q;
  reg        rx_bit_q;
  reg  [3:0] edge_cnt_q;
  reg  [7:0] div_cnt_q;
  reg        m_busy_q;
  reg        sck_prev_q;

  wire       irq_en  = ctrl_q[`SSDP_C_IRQ_EN];
  wire       pen     = ctrl_q[`SSDP_C_PEN];
  wire       master_select    = ctrl_q[`SSDP_C_MASTER_SELECT];
  wire       cpol    = ctrl_q[`SSDP_C_CPOL];
  wire       cpha    = ctrl_q[`SSDP_C_CPHA];
  wire [1:0] spr     = {ctrl_q[`SSDP_C_SPR1], ctrl_q[`SSDP_C_SPR0]};

  // --------------------------------------------------------------------------
  // APB decode: access completes on the second access-phase cycle.
  // --------------------------------------------------------------------------
  wire [ADDR_W-1:0] a_data = {{(ADDR_W-10){1'b0}}, `SSDP_IDX_DATA, 2'b00}; // RULE_16
  wire [ADDR_W-1:0] a_ctrl = {{(ADDR_W-10){1'b0}}, `SSDP_IDX_CTRL, 2'b00}; // RULE_16
  wire [ADDR_W-1:0] a_stat = {{(ADDR_W-10){1'b0}}, `SSDP_IDX_STAT, 2'b00}; // RULE_16

  wire acc     = psel & penable & pready;
  wire hit_dat = (paddr == a_data);
  wire hit_ctl = (paddr == a_ctrl);
  wire hit_sta = (paddr == a_stat);
  wire dat_acc = acc & hit_dat;
  wire dat_wr  = dat_acc & pwrite;
  wire ctl_wr  = acc & hit_ctl & pwrite;
  wire sta_acc = acc & hit_sta;
  wire sta_rd  = sta_acc & ~pwrite;
  wire sta_wr  = sta_acc & pwrite;

  // --------------------------------------------------------------------------
  // Select resolution and serial-side conditions.
  // --------------------------------------------------------------------------
  wire ss_int   = ssm_q ? ssi_q : ss_n_s;        // RULE_10 RULE_11
  wire s_active = pen & ~master_select & ~ss_int;
  wire s_busy   = s_active & (edge_cnt_q != 4'h0);
  wire busy     = m_busy_q | s_busy;
  wire fault    = pen & master_select & ~ss_int;         // RULE_07
  wire din      = master_select ? miso_s : mosi_s;

  // Writes are dropped while a finished byte waits for its status read.
  wire dat_wr_ok = dat_wr & ~(done_q & ~stat_seen_q); // RULE_03
  wire dat_load  = dat_wr_ok & ~busy;            // RULE_14 RULE_22
  wire dat_coll  = dat_wr_ok & busy;             // RULE_04
  wire m_start   = dat_load & pen & master_select;        // RULE_12

  // Master half period; the fastest setting leaves the returning data little
  // margin against the two-flop input delay, a known limitation.
  wire [7:0] half = (ctrl_q[`SSDP_C_DIV2] ? `SSDP_HALF_FAST : `SSDP_HALF_SLOW) << spr;

  wire m_tick = m_busy_q & (div_cnt_q == half - 8'h01);
  wire s_tick = s_active & (sck_s ^ sck_prev_q);
  wire tick   = m_tick | s_tick;

  // --------------------------------------------------------------------------
  // Per-edge shift decisions, shared by master and slave.
  // --------------------------------------------------------------------------
  wire       samp_e  = (edge_cnt_q[0] == cpha);
  wire       shift_e = (edge_cnt_q[0] != cpha) & ~(cpha & (edge_cnt_q == 4'h0));
  wire       last_e  = (edge_cnt_q == `SSDP_LAST_EDGE);
  wire [7:0] rx_byte = {shift_q[6:0], (cpha ? din : rx_bit_q)};
  wire       done_ev = tick & last_e;

  // --------------------------------------------------------------------------
  // Serial engine: shift register, edge counter and master clock.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      shift_q    <= `SSDP_DATA_RST;
      rx_bit_q   <= 1'b0;
      edge_cnt_q <= 4'h0;
      div_cnt_q  <= 8'h00;
      m_busy_q   <= 1'b0;
      sck_o      <= 1'b0;
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      if (dat_load) begin
        shift_q <= pwdata[7:0];                 // RULE_14
      end
      if (m_start) begin
        m_busy_q   <= 1'b1;                     // RULE_12
        div_cnt_q  <= 8'h00;
        edge_cnt_q <= 4'h0;
      end else if (m_busy_q) begin
        if (!pen || !master_select) begin
          // Losing the master role mid-byte abandons the byte.
          m_busy_q   <= 1'b0;
          edge_cnt_q <= 4'h0;
        end else if (m_tick) begin
          div_cnt_q <= 8'h00;
          sck_o     <= ~sck_o;
        end else begin
          div_cnt_q <= div_cnt_q + 8'h01;
        end
      end else if (!s_active) begin
        edge_cnt_q <= 4'h0;
      end
      if (!m_busy_q) begin
        sck_o <= cpol;
      end
      if (tick && !(m_busy_q && (!pen || !master_select))) begin
        edge_cnt_q <= edge_cnt_q + 4'h1;
        if (samp_e) begin
          rx_bit_q <= din;
        end
        if (last_e) begin
          shift_q  <= rx_byte;
          m_busy_q <= 1'b0;
        end else if (shift_e) begin
          shift_q <= {shift_q[6:0], rx_bit_q};
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Receive buffer: only a byte that will not overrun replaces it.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      rx_buf_q <= `SSDP_DATA_RST;
    end else if (done_ev && !done_q) begin
      rx_buf_q <= rx_byte;                      // RULE_13
    end
  end

  // --------------------------------------------------------------------------
  // Control register; a fault drops enable and master in the same edge.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_q <= `SSDP_CTRL_RST;
    end else begin
      if (ctl_wr) begin
        ctrl_q <= pwdata[7:0];
      end
      if (fault) begin
        ctrl_q[`SSDP_C_PEN]  <= 1'b0;           // RULE_19
        ctrl_q[`SSDP_C_MASTER_SELECT] <= 1'b0;           // RULE_19
      end
    end
  end

  // --------------------------------------------------------------------------
  // Status flags. Clears are written first so a same-cycle set wins.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      done_q      <= 1'b0;                      // RULE_17
      write_collision_flag_q      <= 1'b0;
      ovr_q       <= 1'b0;
      mode_fault_flag_q      <= 1'b0;
      sod_q       <= 1'b0;
      ssm_q       <= 1'b0;
      ssi_q       <= 1'b0;
      stat_seen_q <= 1'b0;
      mode_fault_flag_arm_q  <= 1'b0;
    end else begin
      // Only the three mode bits are writable; bit 3 and flags are ignored.
      if (sta_wr) begin
        sod_q <= pwdata[`SSDP_S_SOD];           // RULE_17
        ssm_q <= pwdata[`SSDP_S_SSM];
        ssi_q <= pwdata[`SSDP_S_SSI];
      end
      // First half of the done and collision clearing sequence.
      if (sta_rd && (done_q || write_collision_flag_q)) begin
        stat_seen_q <= 1'b1;                    // RULE_02 RULE_21
      end
      if (dat_acc && stat_seen_q) begin
        done_q      <= 1'b0;                    // RULE_02
        write_collision_flag_q      <= 1'b0;                    // RULE_21
        stat_seen_q <= 1'b0;
      end
      if (sta_rd) begin
        ovr_q <= 1'b0;                          // RULE_06
      end
      if (sta_acc && mode_fault_flag_q) begin
        mode_fault_flag_arm_q <= 1'b1;                     // RULE_08
      end
      if (ctl_wr && mode_fault_flag_arm_q) begin
        mode_fault_flag_q     <= 1'b0;                     // RULE_08
        mode_fault_flag_arm_q <= 1'b0;
      end
      // Hardware sets.
      if (done_ev) begin
        done_q <= 1'b1;                         // RULE_01
        if (done_q) begin
          ovr_q <= 1'b1;                        // RULE_05 RULE_20
        end
      end
      if (dat_coll) begin
        write_collision_flag_q <= 1'b1;                         // RULE_04
      end
      if (fault) begin
        mode_fault_flag_q     <= 1'b1;                     // RULE_07
        mode_fault_flag_arm_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read mux; unmapped addresses read zero and signal an error.
  // --------------------------------------------------------------------------
  reg [7:0] rd_byte;
  always @* begin
    rd_byte = 8'h00;
    if (hit_dat) begin
      rd_byte = rx_buf_q;                       // RULE_13
    end else if (hit_ctl) begin
      rd_byte = ctrl_q;
    end else if (hit_sta) begin
      rd_byte = {done_q, write_collision_flag_q, ovr_q, mode_fault_flag_q, 1'b0, sod_q, ssm_q, ssi_q};
    end
  end

  // --------------------------------------------------------------------------
  // APB answer: one wait state, so pready rises in the second access cycle.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && penable && !pready) begin
      pready  <= 1'b1;
      pslverr <= ~(hit_dat | hit_ctl | hit_sta);
      prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Pin drivers and interrupt, all registered.
  // --------------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      sck_oe      <= 1'b0;
      mosi_o      <= 1'b0;
      mosi_oe     <= 1'b0;
      miso_o      <= 1'b0;
      miso_oe     <= 1'b0;
      ss_pin_free <= 1'b0;
      irq         <= 1'b0;
    end else begin
      sck_oe      <= pen & master_select;
      mosi_o      <= shift_q[7];
      miso_o      <= shift_q[7];
      // A slave only drives its data line while selected, so slaves sharing
      // the line never fight.
      mosi_oe     <= pen & master_select & ~sod_q;       // RULE_09
      miso_oe     <= s_active & ~sod_q;         // RULE_09
      ss_pin_free <= ssm_q;                     // RULE_10
      irq         <= irq_en & (done_q | mode_fault_flag_q | ovr_q); // RULE_18 RULE_01
    end
  end

endmodule // ssdp_core

// [hdl/ssdp_sync.v]
`timescale 1ns/100ps

// Two-stage synchroniser for a bundle of unrelated pin levels.
module ssdp_sync #(
  parameter         W       = 4,
  parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
  input  wire         core_clk,
  input  wire         rst_n,
  input  wire [W-1:0] pin_in,
  output wire [W-1:0] pin_sync
);

  // --------------------------------------------------------------------------
  // One pair of flops per bit; only the second stage leaves this module.
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // The first stage may go metastable, so nothing but the second reads it.
      always @(posedge core_clk) begin
        if (!rst_n) begin
          meta_q <= RST_VAL[gi];
          sync_q <= RST_VAL[gi];
        end else begin
          meta_q <= pin_in[gi];
          sync_q <= meta_q;
        end
      end
      assign pin_sync[gi] = sync_q;
    end
  endgenerate

endmodule // ssdp_sync

// [tb/ssdp_core_assertions.sv]
`timescale 1ns/100ps

module ssdp_core_assertions #(
  parameter ADDR_W = 12
) (
  input wire              core_clk,
  input wire              rst_n,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       prdata,
  input wire              pready,
  input wire              pslverr,
  input wire              sck_oe,
  input wire              mosi_oe,
  input wire              miso_oe,
  input wire              ss_n_i,
  input wire              ss_pin_free,
  input wire              irq
);
  // ------------------------------------------------------------------
  // Decode helpers and properties.
  // ------------------------------------------------------------------
  localparam [ADDR_W-1:0] A_DATA = 12'h0c4;
  localparam [ADDR_W-1:0] A_CTRL = 12'h0c8;
  localparam [ADDR_W-1:0] A_STAT = 12'h0cc;
  // Completed accesses; a status read carries the flags in prdata.
  wire acc  = psel && penable && pready;
  wire rd_s = acc && !pwrite && (paddr == A_STAT);
  wire hit  = (paddr == A_DATA) || (paddr == A_CTRL) || (paddr == A_STAT);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_OE_MOSI: assert property (mosi_oe |-> sck_oe)
    else $error("data out driven while not an enabled master");
  AST_OE_MISO: assert property (miso_oe |-> !sck_oe)
    else $error("slave data out driven in master mode");
  AST_DECODE: assert property (acc |-> (pslverr == !hit))
    else $error("register decode mismatch");
  AST_ERR: assert property (pslverr |-> pready ##1 !pready)
    else $error("error response outside a one cycle answer");
  AST_RSV: assert property (rd_s |-> prdata[3] == 1'b0 && prdata[31:8] == 24'h00_0000)
    else $error("reserved status bits not zero");
  AST_PINFREE: assert property (rd_s |-> prdata[1] == ss_pin_free)
    else $error("select pin release differs from status");
  AST_FAULT: assert property ($fell(ss_n_i) && sck_oe && !ss_pin_free |-> ##[1:6] !sck_oe)
    else $error("mode fault did not leave master mode");
  AST_IRQ: assert property (irq && rd_s |-> (prdata[7] || prdata[5] || prdata[4]))
    else $error("interrupt without a pending flag");
endmodule // ssdp_core_assertions

bind ssdp_core ssdp_core_assertions #(.ADDR_W(ADDR_W)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .ss_n_i(ss_n_i), .ss_pin_free(ss_pin_free), .irq(irq)
);

// [tb/ssdp_core_bench.sv]
`timescale 1ns/100ps

module ssdp_core_bench;
  // ------------------------------------------------------------------
  // Stimulus, model and checks.
  // ------------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic        sck_i    = 1'b0;
  logic        mosi_i   = 1'b0;
  logic        ss_n_i   = 1'b1;
  logic        ld       = 1'b0;
  logic [7:0]  mtx      = 8'h00;
  logic [7:0]  b;
  logic [7:0]  t;
  logic [7:0]  srx;
  logic [31:0] seed;
  int          error_cnt;
  int          n_compared;
  wire  [31:0] prdata;
  wire  [7:0]  mrx;
  wire         pready, pslverr, sck_o, sck_oe, mosi_o, mosi_oe;
  wire         miso_i, miso_o, miso_oe, ss_pin_free, irq;
  // Clock at 200 MHz.
  always #2.5 core_clk = ~core_clk;
  ssdp_core dut (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sck_i(sck_i), .sck_o(sck_o),
    .sck_oe(sck_oe), .mosi_i(mosi_i), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_i), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_n_i),
    .ss_pin_free(ss_pin_free), .irq(irq)
  );
  ssdp_slave_model u_slv (
    .sck(sck_o), .mosi(mosi_o), .ld(ld), .tx(mtx), .miso(miso_i), .rx(mrx)
  );
  function automatic logic [7:0] rb();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  task test_done;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // Arguments are copied at the call, so callers let the output settle first.
  task chk1(input logic g, input logic e);
    chk8({7'h00, g}, {7'h00, e});
  endtask
  // One APB transfer; request held until pready is seen at an edge.
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d,
           output logic [7:0] r, output logic er);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (pready !== 1'b1 && i < 40);
    r = prdata[7:0];
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 40) begin
      error_cnt++;
      test_done();
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    acc(1'b1, a, d, r, e);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] ed, input logic ee);
    logic [7:0] r;
    logic       e;
    acc(1'b0, a, 8'h00, r, e);
    chk8(r, ed);
    chk8({7'h00, e}, {7'h00, ee});
  endtask
  task wait_irq;
    int i;
    i = 0;
    while (irq !== 1'b1 && i < 600) begin
      @(posedge core_clk);
      i++;
    end
    if (i >= 600) begin
      error_cnt++;
      test_done();
    end
  endtask
  task load(input logic [7:0] v);
    mtx = v;
    ld = 1'b1;
    #1 ld = 1'b0;
  endtask
  // Master in the far side's place: a 48 ns link clock, still between frames.
  task slv(input logic [7:0] v);
    int k;
    @(posedge core_clk);
    #1.3;
    for (k = 7; k >= 0; k--) begin
      mosi_i = v[k];
      #12 sck_i = 1'b1;
      srx = {srx[6:0], miso_o};
      #24 sck_i = 1'b0;
      #12;
    end
    mosi_i = ~mosi_i;
  endtask
  // Main sequence.
  initial begin
    error_cnt = 0;
    n_compared = 0;
    seed = 32'h0000_7e86;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(12'h0c8, 8'h00, 1'b0);
    rd(12'h0cc, 8'h00, 1'b0);
    rd(12'h0d0, 8'h00, 1'b1);
    b = rb() & 8'h07;
    wr(12'h0cc, b | 8'hf0);
    rd(12'h0cc, b, 1'b0);
    repeat (3) @(posedge core_clk);
    chk1(ss_pin_free, b[1]);
    $display("test registers done");
    wr(12'h0cc, 8'h03);
    wr(12'h0c8, 8'hd1);
    t = rb();
    load(rb());
    wr(12'h0c4, t);
    wait_irq();
    wr(12'h0c4, ~t);
    rd(12'h0cc, 8'h83, 1'b0);
    chk8(mrx, t);
    rd(12'h0c4, mtx, 1'b0);
    // A write wrongly accepted above would have finished a byte by now.
    repeat (150) @(posedge core_clk);
    rd(12'h0cc, 8'h03, 1'b0);
    repeat (3) @(posedge core_clk);
    chk1(irq, 1'b0);
    wr(12'h0cc, 8'h07);
    repeat (3) @(posedge core_clk);
    chk1(mosi_oe, 1'b0);
    wr(12'h0cc, 8'h03);
    repeat (3) @(posedge core_clk);
    chk1(mosi_oe, 1'b1);
    load(rb());
    t = rb();
    wr(12'h0c4, t);
    wr(12'h0c4, ~t);
    wait_irq();
    rd(12'h0cc, 8'hc3, 1'b0);
    chk8(mrx, t);
    rd(12'h0c4, mtx, 1'b0);
    rd(12'h0cc, 8'h03, 1'b0);
    $display("test master done");
    wr(12'h0cc, 8'h00);
    // Let the pin release show as taken back before the select pin drops.
    repeat (2) @(posedge core_clk);
    ss_n_i <= 1'b0;
    wait_irq();
    ss_n_i <= 1'b1;
    rd(12'h0c8, 8'h81, 1'b0);
    wr(12'h0c8, 8'h81);
    rd(12'h0cc, 8'h10, 1'b0);
    wr(12'h0c8, 8'h81);
    rd(12'h0cc, 8'h00, 1'b0);
    $display("test fault done");
    wr(12'h0c8, 8'hc0);
    wr(12'h0cc, 8'h03);
    repeat (3) @(posedge core_clk);
    chk1(miso_oe, 1'b0);
    slv(rb());
    rd(12'h0cc, 8'h03, 1'b0);
    wr(12'h0cc, 8'h02);
    repeat (3) @(posedge core_clk);
    chk1(miso_oe, 1'b1);
    b = rb();
    wr(12'h0c4, b);
    t = rb();
    slv(t);
    chk8(srx, b);
    slv(rb());
    wait_irq();
    rd(12'h0cc, 8'ha2, 1'b0);
    rd(12'h0cc, 8'h82, 1'b0);
    rd(12'h0c4, t, 1'b0);
    rd(12'h0cc, 8'h02, 1'b0);
    $display("test slave done");
    test_done();
  end
endmodule // ssdp_core_bench

// [tb/ssdp_slave_model.sv]
`timescale 1ns/100ps

module ssdp_slave_model (
  input  wire        sck,
  input  wire        mosi,
  input  wire        ld,
  input  wire  [7:0] tx,
  output logic       miso,
  output logic [7:0] rx
);
  // ------------------------------------------------------------------
  // Mode 0 serial slave.
  // ------------------------------------------------------------------
  logic [7:0] sh;
  int         cnt;
  // Start from a known idle state.
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
    cnt = 0;
  end
  // A fresh byte is loaded before the master starts the exchange.
  always @(posedge ld) begin
    sh = tx;
    cnt = 0;
    miso = tx[7];
  end
  // The master's bit is taken on the rising edge.
  always @(posedge sck) rx <= {rx[6:0], mosi};
  // After the eighth bit the line is not driven, so show the inverse, never a held value.
  always @(negedge sck) begin
    sh = {sh[6:0], 1'b0};
    cnt++;
    miso <= (cnt == 8) ? ~miso : sh[7];
  end
endmodule // ssdp_slave_model
